// file: ssr_pkg.sv
// package for the supply status / scratch register bank and its spi link
// assumes one 200 MHz clock domain on each end
package ssr_pkg;
  localparam int FRAME_W = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] ADDR_SCRATCH_LO = 7'h1E;
  localparam logic [6:0] ADDR_SCRATCH_HI = 7'h1F;
  localparam logic [6:0] ADDR_SUP_A = 7'h40;
  localparam logic [6:0] ADDR_SUP_B = 7'h41;
  localparam logic [6:0] ADDR_THERM = 7'h42;
  localparam logic [6:0] ADDR_DEVINFO = 7'h43;
  localparam logic [6:0] ADDR_BUS = 7'h44;
  localparam logic [6:0] ADDR_WAKE0 = 7'h46;
  localparam logic [6:0] ADDR_WAKE1 = 7'h47;
  localparam logic [6:0] ADDR_WAKE_LVL = 7'h48;
  localparam logic [6:0] ADDR_IO_OC = 7'h54;
  localparam logic [6:0] ADDR_IO_OL = 7'h55;
  localparam logic [6:0] ADDR_ID = 7'h7E;
  // frame bit positions
  localparam int POS_MODE = 7;
  localparam int POS_DATA = 8;
  // supply_fault_flags_a fields
  localparam int BIT_BAT_UV = 6;
  localparam int BIT_BAT_OV = 5;
  localparam int BIT_RAIL_OV = 1;
  localparam int BIT_RAIL_WARN = 0;
  localparam logic [7:0] SUP_A_RC_MASK = 8'h63;
  localparam logic [7:0] SUP_A_RESTART_KEEP = 8'h63;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // arbitrary identification value
  localparam logic [7:0] ID_VALUE = 8'h5A;
  // host drives sclk at clk/32: 160 ns at 200 MHz
  localparam int SCLK_HALF = 16;
  typedef enum logic [1:0] {SSR_NORMAL, SSR_STOP, SSR_OTHER} ssr_mode_t;
endpackage

// file: ssr_link_if.sv
// spi link between host master and register-bank device
// csn low frames exactly 16 sclk cycles
`timescale 1ns/1ps
interface ssr_link_if;
  logic sclk;
  logic csn;
  logic mosi;
  logic miso;
  modport host (output sclk, output csn, output mosi, input miso);
  modport dev (input sclk, input csn, input mosi, output miso);
endinterface

// file: ssr_sync.sv
// two-flop synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
module ssr_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: ssr_dev.sv
// device end: spi slave with scratch bytes and supply fault flags
// assumes host keeps csn high between frames and sends 16 bits lsb first
// Functional notes
// - scratch bytes at 0x1E and 0x1F, rw
// - scratch zero on power-up, kept on soft reset
// - scratch writes only in normal mode
// - scratch kept through fail-safe, restart, soft reset
// - high scratch byte supplies bits 15:8
// - 16-bit frame: address, mode bit, data
// - data bits occupy frame bits 8-15
// - mode bit 0 reads status unchanged
// - mode bit 1 clears clearable status flags
// - status flags sticky until host clears
// - decode status 0x40-0x44, 0x46-0x48, 0x54-0x55, id 0x7E
// - flags reset on por/soft reset, restart keeps
// - bit 6 battery undervolt when rail enabled
// - bit 5 battery overvolt when rail enabled
// - bit 1 rail overvolt, bit 0 prewarn
// - stop mode gates undervolt except peak/prewarn
// - overvolt always with charge pump and rail enabled
// - bits 7 and 4:2 read zero
`timescale 1ns/1ps
module ssr_dev (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // link
  ssr_link_if.dev link,
  // chip state
  input wire ssr_pkg::ssr_mode_t chip_mode,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic rail_enabled,
  input wire logic charge_pump_enable,
  input wire logic load_peak_threshold,
  // analogue comparators, asynchronous
  input wire logic bat_uv_raw,
  input wire logic bat_ov_raw,
  input wire logic rail_ov_raw,
  input wire logic rail_warn_raw,
  // other status bytes, held elsewhere
  input wire logic [7:0] other_status [7],
  // observation
  output logic [15:0] scratch_word,
  output logic [7:0] supply_fault_flags_a,
  output logic frame_done
);
  logic sclk_s, csn_s, mosi_s, sclk_prev_q;
  logic uv_s, ov_s, rov_s, warn_s;
  logic [15:0] shift_q;
  logic [7:0] miso_sh_q;
  logic [4:0] cnt_q;
  logic miso_q;
  logic [7:0] scratch_lo_q, scratch_hi_q, sup_a_q;
  logic done_q, csn_prev_q;
  logic [6:0] addr;
  logic clr;
  logic [7:0] set_vec, reply;
  logic uv_mon, ov_mon, in_stop;

  ssr_sync u_sclk (.clk(clk), .rst(rst), .d(link.sclk), .q(sclk_s));
  ssr_sync u_csn (.clk(clk), .rst(rst), .d(link.csn), .q(csn_s));
  ssr_sync u_mosi (.clk(clk), .rst(rst), .d(link.mosi), .q(mosi_s));
  ssr_sync u_uv (.clk(clk), .rst(rst), .d(bat_uv_raw), .q(uv_s));
  ssr_sync u_ov (.clk(clk), .rst(rst), .d(bat_ov_raw), .q(ov_s));
  ssr_sync u_rov (.clk(clk), .rst(rst), .d(rail_ov_raw), .q(rov_s));
  ssr_sync u_warn (.clk(clk), .rst(rst), .d(rail_warn_raw), .q(warn_s));

  function automatic logic [7:0] read_byte(input logic [6:0] a, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic [7:0] sa,
                                           input logic [7:0] oth [7]);
    unique case (a)
      ssr_pkg::ADDR_SCRATCH_LO: read_byte = lo;
      ssr_pkg::ADDR_SCRATCH_HI: read_byte = hi;
      ssr_pkg::ADDR_SUP_A: read_byte = sa & ssr_pkg::SUP_A_RC_MASK;
      ssr_pkg::ADDR_SUP_B: read_byte = oth[0];
      ssr_pkg::ADDR_THERM: read_byte = oth[1];
      ssr_pkg::ADDR_DEVINFO: read_byte = oth[2];
      ssr_pkg::ADDR_BUS: read_byte = oth[3];
      ssr_pkg::ADDR_WAKE0: read_byte = oth[4];
      ssr_pkg::ADDR_WAKE1: read_byte = oth[5];
      ssr_pkg::ADDR_WAKE_LVL: read_byte = oth[6];
      ssr_pkg::ADDR_IO_OC: read_byte = ssr_pkg::RESET_BYTE;
      ssr_pkg::ADDR_IO_OL: read_byte = ssr_pkg::RESET_BYTE;
      ssr_pkg::ADDR_ID: read_byte = ssr_pkg::ID_VALUE;
      default: read_byte = ssr_pkg::RESET_BYTE;
    endcase
  endfunction

  // sample on rising sclk, shift out on falling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
      shift_q <= 16'h0000;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      csn_prev_q <= csn_s;
      done_q <= 1'b0;
      if (csn_s)
        cnt_q <= 5'h00;
      else if (sclk_s && !sclk_prev_q)
      begin
        shift_q <= {mosi_s, shift_q[15:1]};
        cnt_q <= cnt_q + 5'h01;
      end
      // frame ends on csn rise; a short frame is dropped
      if (csn_s && !csn_prev_q && cnt_q == 5'(ssr_pkg::FRAME_W))
        done_q <= 1'b1;
    end
  end

  assign addr = shift_q[ssr_pkg::ADDR_W-1:0];
  assign clr = done_q && shift_q[ssr_pkg::POS_MODE];
  // after eight lsb-first shifts the address sits just below the mode bit
  assign reply = read_byte(shift_q[ssr_pkg::POS_DATA +: ssr_pkg::ADDR_W], scratch_lo_q,
                           scratch_hi_q, sup_a_q, other_status);

  // reply byte: loaded after address phase, shifted on falling sclk
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      miso_sh_q <= 8'h00;
      miso_q <= 1'b0;
    end
    else if (!csn_s && !sclk_s && sclk_prev_q)
    begin
      if (cnt_q == 5'(ssr_pkg::POS_DATA))
      begin
        miso_sh_q <= reply >> 1;
        miso_q <= reply[0];
      end
      else if (cnt_q > 5'(ssr_pkg::POS_DATA))
      begin
        miso_q <= miso_sh_q[0];
        miso_sh_q <= miso_sh_q >> 1;
      end
      else
        miso_q <= 1'b0;
    end
  end
  assign link.miso = miso_q;

  // scratch: only power-on reset clears it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scratch_lo_q <= ssr_pkg::RESET_BYTE;
      scratch_hi_q <= ssr_pkg::RESET_BYTE;
    end
    else if (done_q && shift_q[ssr_pkg::POS_MODE] && chip_mode == ssr_pkg::SSR_NORMAL)
    begin
      if (addr == ssr_pkg::ADDR_SCRATCH_LO)
        scratch_lo_q <= shift_q[15:8];
      if (addr == ssr_pkg::ADDR_SCRATCH_HI)
        scratch_hi_q <= shift_q[15:8];
    end
  end

  // monitoring windows
  assign in_stop = chip_mode == ssr_pkg::SSR_STOP;
  assign uv_mon = rail_enabled && (!in_stop || load_peak_threshold
                  || sup_a_q[ssr_pkg::BIT_RAIL_WARN]);
  assign ov_mon = rail_enabled && (charge_pump_enable || !in_stop || load_peak_threshold
                  || sup_a_q[ssr_pkg::BIT_RAIL_WARN]);
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[ssr_pkg::BIT_BAT_UV] = uv_s && uv_mon;
    set_vec[ssr_pkg::BIT_BAT_OV] = ov_s && ov_mon;
    set_vec[ssr_pkg::BIT_RAIL_OV] = rov_s;
    set_vec[ssr_pkg::BIT_RAIL_WARN] = warn_s;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sup_a_q <= ssr_pkg::RESET_BYTE;
    else if (soft_reset)
      sup_a_q <= ssr_pkg::RESET_BYTE;
    else if (restart)
      sup_a_q <= sup_a_q & ssr_pkg::SUP_A_RESTART_KEEP;
    else if (clr && addr == ssr_pkg::ADDR_SUP_A)
      sup_a_q <= set_vec & ssr_pkg::SUP_A_RC_MASK;
    else
      sup_a_q <= (sup_a_q | set_vec) & ssr_pkg::SUP_A_RC_MASK;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scratch_word <= 16'h0000;
      supply_fault_flags_a <= 8'h00;
      frame_done <= 1'b0;
    end
    else
    begin
      scratch_word <= {scratch_hi_q, scratch_lo_q};
      supply_fault_flags_a <= sup_a_q;
      frame_done <= done_q;
    end
  end
endmodule

// file: ssr_host.sv
// host end: spi master sending one 16-bit frame per request
// assumes device answers data lsb first during bits 8-15
`timescale 1ns/1ps
module ssr_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  ssr_link_if.host link,
  // request
  input wire logic req_valid,
  input wire logic [6:0] req_addr,
  input wire logic req_clear,
  input wire logic [7:0] req_data,
  // answer
  output logic busy,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef enum logic [1:0] {SSR_IDLE, SSR_SHIFT, SSR_END} ssr_hstate_t;
  ssr_hstate_t state_q;
  logic [15:0] tx_q;
  logic [7:0] rx_q;
  logic [4:0] bit_q;
  logic [4:0] div_q;
  logic sclk_q, csn_q, miso_s;

  ssr_sync u_miso (.clk(clk), .rst(rst), .d(link.miso), .q(miso_s));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= SSR_IDLE;
      tx_q <= 16'h0000;
      rx_q <= 8'h00;
      bit_q <= 5'h00;
      div_q <= 5'h00;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      busy <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        SSR_IDLE:
          if (req_valid)
          begin
            tx_q <= {req_data, req_clear, req_addr};
            csn_q <= 1'b0;
            busy <= 1'b1;
            bit_q <= 5'h00;
            div_q <= 5'h00;
            state_q <= SSR_SHIFT;
          end
        SSR_SHIFT:
          if (div_q == 5'(ssr_pkg::SCLK_HALF - 1))
          begin
            div_q <= 5'h00;
            sclk_q <= !sclk_q;
            if (sclk_q)
            begin
              // falling edge: next bit out
              tx_q <= tx_q >> 1;
              bit_q <= bit_q + 5'h01;
              if (bit_q == 5'(ssr_pkg::FRAME_W - 1))
                state_q <= SSR_END;
            end
            // rising edge of data bits 8..15: eight samples, lsb first
            else if (bit_q >= 5'(ssr_pkg::POS_DATA))
              rx_q <= {miso_s, rx_q[7:1]};
          end
          else
            div_q <= div_q + 5'h01;
        SSR_END:
          if (div_q == 5'(ssr_pkg::SCLK_HALF - 1))
          begin
            csn_q <= 1'b1;
            busy <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data <= rx_q;
            state_q <= SSR_IDLE;
          end
          else
            div_q <= div_q + 5'h01;
        default: state_q <= SSR_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_q;
  assign link.csn = csn_q;
  assign link.mosi = tx_q[0];
endmodule

// file: ssr_link_monitor.sv
// monitor: framing and bit timing on the spi link between both ends
// assumes clk samples the link and rst is async active high
`timescale 1ns/1ps
module ssr_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_q;
  logic [4:0] rises_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  end
  // counts sclk rises inside one frame, cleared while csn is high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rises_q <= 5'h00;
    else if (csn)
      rises_q <= 5'h00;
    else if (sclk && !sclk_q)
      rises_q <= rises_q + 5'h01;
  end
  a_idle_clock_low: assert property (csn |-> !sclk)
    else $error("sclk moved outside a frame");
  a_sixteen_bits: assert property ($rose(csn) |-> rises_q == 5'd16)
    else $error("frame did not carry sixteen clocks");
  a_frame_span: assert property ($fell(csn) |-> ##[500:600] $rose(csn))
    else $error("frame length out of range");
  a_lead_in: assert property ($fell(csn) |-> !sclk [*8])
    else $error("sclk rose too soon after csn fell");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*8])
    else $error("sclk high phase too short");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi changed while sclk high");
  a_miso_steady: assert property (!csn && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso changed while sclk high");
  a_gap_after: assert property ($rose(csn) |=> csn)
    else $error("csn gap shorter than two cycles");
endmodule

// file: sbc_status_scratch_regs_bench.sv
// bench: host and device ends joined by the link, monitor beside it
// assumes the host end makes sclk from clk
`timescale 1ns/1ps
module sbc_status_scratch_regs_bench;
  logic clk = 0, rst = 1, rv = 0, rc = 0, sr = 0, rs = 0, ren = 1, cp = 0, pk = 0;
  logic [6:0] ra = 7'h00;
  logic [7:0] wd = 8'h00;
  logic busy, rsp_valid, fd;
  logic [7:0] rsp_data, sfa;
  logic [15:0] sw;
  logic [3:0] raw = 4'h0;
  logic [7:0] oth [7];
  ssr_pkg::ssr_mode_t mode = ssr_pkg::SSR_NORMAL;
  int miscompares = 0;
  int checks_done = 0;
  int sent = 0;
  int frames = 0;
  always #2.5 clk = ~clk;
  // frame_done is a one-cycle pulse, counted where it is settled
  always @(negedge clk)
    if (fd === 1'b1)
      frames++;
  ssr_link_if link ();
  ssr_host ssr_host_i (.clk(clk), .rst(rst), .link(link), .req_valid(rv), .req_addr(ra),
    .req_clear(rc), .req_data(wd), .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  ssr_dev ssr_dev_i (.clk(clk), .rst(rst), .link(link), .chip_mode(mode), .soft_reset(sr),
    .restart(rs), .rail_enabled(ren), .charge_pump_enable(cp), .load_peak_threshold(pk),
    .bat_uv_raw(raw[3]), .bat_ov_raw(raw[2]), .rail_ov_raw(raw[1]), .rail_warn_raw(raw[0]),
    .other_status(oth), .scratch_word(sw), .supply_fault_flags_a(sfa), .frame_done(fd));
  ssr_link_monitor ssr_link_monitor_i (.clk(clk), .rst(rst), .sclk(link.sclk),
    .csn(link.csn), .mosi(link.mosi), .miso(link.miso));
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [6:0] a, input logic [15:0] e,
    input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s %h exp %h got %h", nm, a, e, g);
    end
  endtask
  // one frame; waits for the answer under a bound
  task automatic xf(input logic [6:0] a, input logic c, input logic [7:0] d);
    int n;
    ra = a;
    rc = c;
    wd = d;
    rv = 1;
    tk(1);
    rv = 0;
    sent++;
    cmp("busy", a, 16'h0001, {15'h0000, busy});
    n = 0;
    while (rsp_valid !== 1'b1 && n < 800)
    begin
      tk(1);
      n++;
    end
    if (rsp_valid !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    else
    begin
      cmp("idle", a, 16'h0000, {15'h0000, busy});
      tk(8);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    xf(a, 1'b0, 8'h00);
    cmp("read", a, {8'h00, e}, {8'h00, rsp_data});
  endtask
  // raw causes held long enough to pass the synchroniser
  task automatic pl(input logic [3:0] m);
    raw = m;
    tk(12);
    raw = 4'h0;
    tk(12);
  endtask
  task automatic pulse_resets(input logic s, input logic r);
    sr = s;
    rs = r;
    tk(1);
    sr = 0;
    rs = 0;
    tk(4);
  endtask
  initial
  begin
    foreach (oth[i]) oth[i] = 8'(8'h11 * (i + 1));
    tk(3);
    rst = 0;
    rd(7'h1E, 8'h00);
    rd(7'h40, 8'h00);
    xf(7'h1E, 1'b1, 8'hA5);
    xf(7'h1F, 1'b1, 8'h3C);
    rd(7'h1F, 8'h3C);
    cmp("word", 7'h1F, 16'h3CA5, sw);
    mode = ssr_pkg::SSR_STOP;
    xf(7'h1E, 1'b1, 8'hFF);
    rd(7'h1E, 8'hA5);
    pulse_resets(1'b1, 1'b1);
    rd(7'h1F, 8'h3C);
    rd(7'h7E, ssr_pkg::ID_VALUE);
    rd(7'h41, 8'h11);
    rd(7'h48, 8'h77);
    rd(7'h54, 8'h00);
    mode = ssr_pkg::SSR_OTHER;
    xf(7'h1F, 1'b1, 8'h00);
    rd(7'h1F, 8'h3C);
    mode = ssr_pkg::SSR_NORMAL;
    pl(4'hF);
    rd(7'h40, 8'h63);
    cmp("flags", 7'h40, 16'h0063, {8'h00, sfa});
    rd(7'h40, 8'h63);
    xf(7'h40, 1'b1, 8'hFF);
    rd(7'h40, 8'h00);
    ren = 0;
    pl(4'hC);
    rd(7'h40, 8'h00);
    ren = 1;
    mode = ssr_pkg::SSR_STOP;
    pl(4'hC);
    rd(7'h40, 8'h00);
    cp = 1;
    pl(4'h4);
    rd(7'h40, 8'h20);
    pk = 1;
    pl(4'h8);
    rd(7'h40, 8'h60);
    pulse_resets(1'b0, 1'b1);
    rd(7'h40, 8'h60);
    pulse_resets(1'b1, 1'b0);
    rd(7'h40, 8'h00);
    cmp("word", 7'h1E, 16'h3CA5, sw);
    mode = ssr_pkg::SSR_NORMAL;
    raw = 4'h2;
    tk(12);
    xf(7'h40, 1'b1, 8'hFF);
    raw = 4'h0;
    tk(12);
    rd(7'h40, 8'h02);
    cmp("frames", 7'h00, 16'(sent), 16'(frames));
    conclude();
  end
endmodule
